// *** src/sdt_pkg.sv ***
// Constants and types for the SDRAM command timing core
package sdt_pkg;
  localparam int CLK_PERIOD_PS        = 10000;
  localparam int DATA_W               = 16;
  localparam int COL_W                = 8;
  localparam int ROW_W                = 11;
  localparam int READ_MASK_LATENCY    = 2;
  localparam int WRITE_MASK_LATENCY   = 0;
  localparam int SREX_EDGE            = 2;
  localparam int ROW_CYCLE_TIME_PS    = 70000;
  localparam int ROW_CYCLE_CLKS       = (ROW_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SREX_BUSY_CLKS       = 2 + ROW_CYCLE_CLKS;
  localparam logic [1:0] LAT_DEFAULT  = 2'h3;
  localparam logic [2:0] BL_FULL_PAGE = 3'h7;
  localparam logic [2:0] BL_RESET     = 3'h7;
  // Command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP      = 4'h7;
  localparam logic [3:0] CMD_ACT      = 4'h3;
  localparam logic [3:0] CMD_READ     = 4'h5;
  localparam logic [3:0] CMD_WRITE    = 4'h4;
  localparam logic [3:0] CMD_STOP     = 4'h6;
  localparam logic [3:0] CMD_PRE      = 4'h2;
  localparam logic [3:0] CMD_REF      = 4'h1;
  localparam logic [3:0] CMD_MRS      = 4'h0;
  localparam int MRS_LAT_LSB          = 4;
  localparam int MRS_BL_LSB           = 0;
  localparam int LAT_PIPE             = 4;

  typedef enum logic [3:0] {
    SDT_IDLE  = 4'h1,
    SDT_READ  = 4'h2,
    SDT_WRITE = 4'h4,
    SDT_SELF  = 4'h8
  } sdt_state_e;
endpackage

// *** src/sdt_lat_pipe.sv ***
// Read data and enable delay line indexed by the programmed read latency
`timescale 1ns/10ps
module sdt_lat_pipe
  import sdt_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   sys_rst_in,
  // Stage input
  input  wire logic                   valid_in,
  input  wire logic [DATA_W-1:0]      data_in,
  input  wire logic [1:0]             lat_in,
  // Delayed output, taps index 0 up to latency minus 1
  output logic                        valid_out,
  output logic [DATA_W-1:0]           data_out
);
  import sdt_pkg::*;

  logic [LAT_PIPE-1:0]     vld_ff,  nxt_vld;
  logic [DATA_W-1:0]       dat_ff   [LAT_PIPE];
  logic [DATA_W-1:0]       nxt_dat  [LAT_PIPE];

  always_comb begin
    nxt_vld    = {vld_ff[LAT_PIPE-2:0], valid_in};
    nxt_dat[0] = data_in;
    for (int i = 1; i < LAT_PIPE; i++) begin
      nxt_dat[i] = dat_ff[i-1];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      vld_ff <= '0;
    end else begin
      vld_ff <= nxt_vld;
    end
    dat_ff <= nxt_dat;
  end

  // Tap latency-1 so the top-level output register adds the last stage
  always_comb begin
    valid_out = vld_ff[lat_in - 2'h1];
    data_out  = dat_ff[lat_in - 2'h1];
  end
endmodule

// *** src/sdt_core.sv ***
// Command decoder, storage and timed data path of the two-bank SDRAM model
`timescale 1ns/10ps
module sdt_core
  import sdt_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   sys_rst_in,
  // Command and address
  input  wire logic                   clk_gate_in,
  input  wire logic [3:0]             cmd_in,
  input  wire logic                   bank_in,
  input  wire logic [ROW_W-1:0]       addr_in,
  // Data
  input  wire logic [1:0]             data_mask_in,
  input  wire logic [DATA_W-1:0]      dq_in,
  output logic [DATA_W-1:0]           dq_out,
  output logic [1:0]                  dq_oe_out,
  // Status
  output logic                        self_refresh_out,
  output logic                        srex_busy_out
);
  import sdt_pkg::*;

  localparam int DEPTH = 2 * (1 << COL_W);

  logic [DATA_W-1:0]       mem [DEPTH];
  sdt_state_e              state_ff,   nxt_state;
  logic [1:0]              lat_ff,     nxt_lat;
  logic [2:0]              bl_ff,      nxt_bl;
  logic                    bank_ff,    nxt_bank;
  logic [COL_W-1:0]        col_ff,     nxt_col;
  logic [8:0]              left_ff,    nxt_left;
  logic [1:0]              gate_ff,    nxt_gate;
  logic [5:0]              srex_ff,    nxt_srex;
  logic [1:0]              dqm1_ff,    dqm2_ff;
  logic [DATA_W-1:0]       dq_ff,      nxt_dq;
  logic [1:0]              oe_ff,      nxt_oe;
  logic                    srex_bsy_ff;
  logic                    rd_issue;
  logic                    wr_en;
  logic [COL_W:0]          wr_idx;
  logic                    pipe_vld;
  logic [DATA_W-1:0]       pipe_dat;

  function automatic logic [8:0] burst_len(input logic [2:0] bl);
    burst_len = (bl == BL_FULL_PAGE) ? 9'h100 : (9'h001 << bl);
  endfunction

  function automatic logic [COL_W:0] mem_index(input logic b, input logic [COL_W-1:0] c);
    mem_index = {b, c};
  endfunction

  // Command sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_lat   = lat_ff;
    nxt_bl    = bl_ff;
    nxt_bank  = bank_ff;
    nxt_col   = col_ff;
    nxt_left  = left_ff;
    nxt_gate  = {gate_ff[0], clk_gate_in};
    nxt_srex  = (srex_ff != 6'h00) ? srex_ff - 6'h01 : 6'h00;
    rd_issue  = 1'b0;
    wr_en     = 1'b0;
    wr_idx    = mem_index(bank_ff, col_ff);
    case (state_ff)
      SDT_SELF: begin
        // Exit on the second edge seeing clock enable high
        if (gate_ff[0] && clk_gate_in) begin
          nxt_state = SDT_IDLE;
          nxt_srex  = 6'(SREX_BUSY_CLKS);
        end
      end
      default: begin
        // Burst in progress advances one column per clock
        if (state_ff == SDT_READ) begin
          rd_issue  = 1'b1;
          nxt_col   = col_ff + 8'h01;
          nxt_left  = left_ff - 9'h001;
          if (left_ff == 9'h001) begin
            nxt_state = SDT_IDLE;
          end
        end else if (state_ff == SDT_WRITE) begin
          wr_en     = (cmd_in != CMD_STOP) && (cmd_in != CMD_READ);
          nxt_col   = col_ff + 8'h01;
          nxt_left  = left_ff - 9'h001;
          if (left_ff == 9'h001) begin
            nxt_state = SDT_IDLE;
          end
        end
        // Read, write, stop, precharge and self refresh entry interrupt a running burst; one clock apart is fine
        if (cmd_in == CMD_READ) begin
          // First word leaves on the command edge, the burst goes on from the next column
          nxt_state = SDT_READ;
          nxt_bank  = bank_in;
          nxt_col   = addr_in[COL_W-1:0] + 8'h01;
          nxt_left  = burst_len(bl_ff) - 9'h001;
          rd_issue  = 1'b0;
          if (bl_ff == 3'h0) begin
            nxt_state = SDT_IDLE;
          end
        end else if (cmd_in == CMD_WRITE) begin
          nxt_state = SDT_WRITE;
          nxt_bank  = bank_in;
          nxt_col   = addr_in[COL_W-1:0] + 8'h01;
          nxt_left  = burst_len(bl_ff) - 9'h001;
          wr_en     = 1'b1;
          wr_idx    = mem_index(bank_in, addr_in[COL_W-1:0]);
          if (bl_ff == 3'h0) begin
            nxt_state = SDT_IDLE;
          end
        end else if (cmd_in == CMD_STOP || cmd_in == CMD_PRE) begin
          // Reads already issued still drain; no new word on the stop edge
          nxt_state = SDT_IDLE;
          rd_issue  = 1'b0;
        end else if (cmd_in == CMD_MRS) begin
          nxt_lat   = addr_in[MRS_LAT_LSB +: 2];
          nxt_bl    = addr_in[MRS_BL_LSB +: 3];
        end else if (cmd_in == CMD_REF && !clk_gate_in) begin
          nxt_state = SDT_SELF;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_ff <= SDT_IDLE;
      lat_ff   <= LAT_DEFAULT;
      bl_ff    <= BL_RESET;
      bank_ff  <= 1'b0;
      col_ff   <= '0;
      left_ff  <= '0;
      gate_ff  <= 2'h3;
      srex_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      lat_ff   <= nxt_lat;
      bl_ff    <= nxt_bl;
      bank_ff  <= nxt_bank;
      col_ff   <= nxt_col;
      left_ff  <= nxt_left;
      gate_ff  <= nxt_gate;
      srex_ff  <= nxt_srex;
    end
  end

  // Byte lanes under mask keep their old value; no mask delay on writes
  always_ff @(posedge clk_sys_in) begin
    if (wr_en) begin
      for (int b = 0; b < 2; b++) begin
        if (!data_mask_in[b]) begin
          mem[wr_idx][b*8 +: 8] <= dq_in[b*8 +: 8];
        end
      end
    end
  end

  sdt_lat_pipe u_pipe (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .valid_in   (rd_issue || (cmd_in == CMD_READ)),
    .data_in    ((cmd_in == CMD_READ) ? mem[mem_index(bank_in, addr_in[COL_W-1:0])]
                                      : mem[mem_index(bank_ff, col_ff)]),
    .lat_in     (lat_ff),
    .valid_out  (pipe_vld),
    .data_out   (pipe_dat)
  );

  // Mask sampled now blanks the lane two edges later
  always_comb begin
    nxt_dq = pipe_dat;
    for (int b = 0; b < 2; b++) begin
      nxt_oe[b] = pipe_vld && !dqm2_ff[b];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      dqm1_ff     <= '0;
      dqm2_ff     <= '0;
      dq_ff       <= '0;
      oe_ff       <= '0;
      srex_bsy_ff <= 1'b0;
    end else begin
      dqm1_ff     <= data_mask_in;
      dqm2_ff     <= dqm1_ff;
      dq_ff       <= nxt_dq;
      oe_ff       <= nxt_oe;
      srex_bsy_ff <= (nxt_srex != 6'h00);
    end
  end

  always_comb begin
    dq_out           = dq_ff;
    dq_oe_out        = oe_ff;
    self_refresh_out = state_ff[3];
    srex_busy_out    = srex_bsy_ff;
  end
endmodule

// *** bench/sdt_core_sva.sv ***
// Port assertions for the SDRAM command timing core
`timescale 1ns/10ps
module sdt_core_sva
  import sdt_pkg::*;
(
  input wire logic              clk_sys_in,
  input wire logic              sys_rst_in,
  input wire logic              clk_gate_in,
  input wire logic [3:0]        cmd_in,
  input wire logic              bank_in,
  input wire logic [ROW_W-1:0]  addr_in,
  input wire logic [1:0]        data_mask_in,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic [1:0]        dq_oe_out,
  input wire logic              self_refresh_out,
  input wire logic              srex_busy_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic [1:0] lat_ff;
  // Latency is rebuilt from mode commands since only ports are visible
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) lat_ff <= LAT_DEFAULT;
    else if (cmd_in == CMD_MRS) lat_ff <= addr_in[5:4];
  end
  property p_srex_hold;
    self_refresh_out && clk_gate_in && !$past(clk_gate_in) |=> self_refresh_out;
  endproperty
  a_srex_hold: assert property (p_srex_hold) else $error("early exit");
  property p_srex_exit;
    self_refresh_out && clk_gate_in && !$past(clk_gate_in) ##1 clk_gate_in |=> !self_refresh_out;
  endproperty
  a_srex_exit: assert property (p_srex_exit) else $error("late exit");
  property p_srex_busy;
    $rose(srex_busy_out) |-> srex_busy_out[*8] ##1 srex_busy_out ##1 !srex_busy_out;
  endproperty
  a_srex_busy: assert property (p_srex_busy) else $error("busy length");
  property p_rmask;
    |data_mask_in |-> ##3 ((dq_oe_out & $past(data_mask_in, 3)) == 2'h0);
  endproperty
  a_rmask: assert property (p_rmask) else $error("masked lane driven");
  property p_read;
    cmd_in == CMD_READ && lat_ff == 2'h3 ##1 (cmd_in != CMD_WRITE)[*3]
      |=> dq_oe_out == ~$past(data_mask_in, 3);
  endproperty
  a_read: assert property (p_read) else $error("read word lanes");
endmodule
bind sdt_core sdt_core_sva i_sdt_core_sva (.clk_sys_in, .sys_rst_in, .clk_gate_in, .cmd_in,
  .bank_in, .addr_in, .data_mask_in, .dq_in, .dq_out, .dq_oe_out, .self_refresh_out,
  .srex_busy_out);

// *** bench/sdt_ctl_model.sv ***
// Controller model driving commands, masks and write data
`timescale 1ns/10ps
module sdt_ctl_model
  import sdt_pkg::*;
(
  input  wire logic        clk_sys_in,
  output logic             gate_out,
  output logic [3:0]       cmd_out,
  output logic [ROW_W-1:0] addr_out,
  output logic [1:0]       mask_out,
  output logic [15:0]      dq_out
);
  // Stop gap rounded up to whole clocks
  localparam int STOP_CLKS = (7000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  initial begin
    gate_out = 1'b1;
    cmd_out = CMD_NOP;
    addr_out = 11'h000;
    mask_out = 2'h0;
    dq_out = 16'h0000;
  end
  // No activate or precharge traffic: rows are not modelled
  task automatic cyc(input logic [3:0] c, input logic [7:0] a, input logic [1:0] m,
                     input logic [15:0] d, input logic g);
    @(negedge clk_sys_in);
    gate_out = g;
    cmd_out = c;
    addr_out = 11'(a);
    mask_out = m;
    // Released lines toggle so a stale word never reads back
    if (c == CMD_WRITE || c == CMD_STOP) dq_out = d;
    else dq_out = ~dq_out;
  endtask
  task automatic wr(input logic [7:0] a, input logic [1:0] m, input logic [15:0] d);
    cyc(CMD_WRITE, a, m, d, 1'b1);
    repeat (STOP_CLKS - 1) cyc(CMD_NOP, a, 2'h3, d, 1'b1);
    cyc(CMD_STOP, a, 2'h0, ~d, 1'b1);
  endtask
endmodule

// *** bench/sdt_core_tb.sv ***
// Self-checking bench for the SDRAM command timing core
`timescale 1ns/10ps
module sdt_core_tb;
  import sdt_pkg::*;
  logic        clk_sys_in;
  logic        sys_rst_in;
  logic        gate;
  logic [3:0]  cmd;
  logic [10:0] addr;
  logic [1:0]  mask;
  logic [15:0] dq_w;
  logic [15:0] dq_r;
  logic [1:0]  oe;
  logic        sr;
  logic        busy;
  int          err_count = 0;
  int          n_checks = 0;
  int          nb;
  // Column, mask, write data, word read back
  logic [41:0] rows [5] = '{{8'h0B, 2'h0, 16'h0F0F, 16'h0F0F}, {8'h0A, 2'h0, 16'h1234, 16'h1234},
    {8'h0A, 2'h1, 16'hABCD, 16'hAB34}, {8'h0A, 2'h2, 16'h5678, 16'hAB78},
    {8'h0B, 2'h3, 16'hFFFF, 16'h0F0F}};
  sdt_ctl_model i_sdt_ctl_model (.clk_sys_in, .gate_out(gate), .cmd_out(cmd), .addr_out(addr),
    .mask_out(mask), .dq_out(dq_w));
  sdt_core i_sdt_core (.clk_sys_in, .sys_rst_in, .clk_gate_in(gate), .cmd_in(cmd),
    .bank_in(1'b0), .addr_in(addr), .data_mask_in(mask), .dq_in(dq_w), .dq_out(dq_r),
    .dq_oe_out(oe), .self_refresh_out(sr), .srex_busy_out(busy));
  task automatic end_sim;
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cy(input logic [3:0] c, input logic [7:0] a, input logic [1:0] m);
    i_sdt_ctl_model.cyc(c, a, m, 16'h0000, 1'b1);
  endtask
  // One word, then a stop right behind the read
  task automatic rd(input logic [7:0] a, input int lat, input logic [15:0] exp);
    cy(CMD_READ, a, 2'h0);
    cy(CMD_STOP, a, 2'h0);
    repeat (lat) cy(CMD_NOP, a, 2'h0);
    chk(16'(oe), 16'h0003);
    chk(dq_r, exp);
    cy(CMD_NOP, a, 2'h0);
    chk(16'(oe), 16'h0000);
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #50000;
    err_count++;
    end_sim();
  end
  initial begin
    sys_rst_in = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    chk({12'h000, oe, sr, busy}, 16'h0000);
    foreach (rows[i]) begin
      i_sdt_ctl_model.wr(rows[i][41:34], rows[i][33:32], rows[i][31:16]);
      rd(rows[i][41:34], 3, rows[i][15:0]);
    end
    cy(CMD_READ, 8'h0A, 2'h0);
    cy(CMD_NOP, 8'h0A, 2'h1);
    cy(CMD_STOP, 8'h0A, 2'h0);
    repeat (2) cy(CMD_NOP, 8'h00, 2'h0);
    chk({oe, 6'h00, dq_r[15:8]}, 16'h80AB);
    cy(CMD_NOP, 8'h00, 2'h0);
    chk(dq_r, 16'h0F0F);
    i_sdt_ctl_model.cyc(CMD_REF, 8'h00, 2'h0, 16'h0000, 1'b0);
    repeat (3) i_sdt_ctl_model.cyc(CMD_NOP, 8'h00, 2'h0, 16'h0000, 1'b0);
    repeat (2) cy(CMD_NOP, 8'h00, 2'h0);
    chk(16'(sr), 16'h0001);
    cy(CMD_NOP, 8'h00, 2'h0);
    chk(16'(sr), 16'h0000);
    nb = 0;
    repeat (20) begin
      if (busy === 1'b1) nb++;
      cy(CMD_NOP, 8'h00, 2'h0);
    end
    chk(16'(nb), 16'(SREX_BUSY_CLKS));
    rd(8'h0A, 3, 16'hAB78);
    cy(CMD_MRS, 8'h27, 2'h0);
    cy(CMD_NOP, 8'h00, 2'h0);
    rd(8'h0B, 2, 16'h0F0F);
    end_sim();
  end
endmodule
